/* rtl/acsp_map.svh */
// register map, field positions, reset values and frame counts
//
// Overview of operation
// - configuration space is reached over the serial port, one byte per address
// - all serial reads and writes are timed by the controller's shift clock
// - data line direction follows the instruction and the bit position in the frame
// - select low enables cycles; while select is high serial activity is ignored
// - master reset input held low restores default configuration
// - frame starts at the first shift clock rise after select falls
// - each frame opens with a sixteen bit instruction from the controller
// - data phase carries one or more bytes set by the two length bits
// - instruction bit 15 selects read or write (leading bit msb first, last bit lsb first); read turns data line to output
// - msb first after power-up; lsb first once the port config bit is set
// - line turns to output after a falling edge, back to input after a rise
// - select tied low when unused disables the port; shared pins become straps
// - in strap mode the shared pin levels are taken as settings at power-on
// - stabilizer strap high enables the duty cycle stabilizer, low disables it
// - map: chip config 0x00-0x02, transfer 0xff, program registers 0x08-0x2a
// - clock control register at 0x09 resets to 0x01
// - default values read with bit 7 as msb and bit 0 as lsb
// - transfer bit write copies staged registers into the active set
`ifndef ACSP_MAP_SVH
`define ACSP_MAP_SVH

// --------------------------------------------------------------
// addresses
// --------------------------------------------------------------
`define ACSP_ADDR_PORT_CFG   8'h00
`define ACSP_ADDR_CHIP_ID    8'h01
`define ACSP_ADDR_GRADE      8'h02
`define ACSP_ADDR_PROG_FIRST 8'h08
`define ACSP_ADDR_CLOCK      8'h09
`define ACSP_ADDR_PROG_LAST  8'h2a
`define ACSP_ADDR_XFER       8'hff
`define ACSP_PROG_COUNT      35
`define ACSP_CLOCK_IDX       1

// --------------------------------------------------------------
// fields and reset values
// --------------------------------------------------------------
`define ACSP_PC_LSB_HI       6
`define ACSP_PC_SRST_HI      5
`define ACSP_PC_SRST_LO      2
`define ACSP_PC_LSB_LO       1
`define ACSP_PC_FIXED        8'h18
`define ACSP_CLK_DCS_BIT     0
`define ACSP_XFER_BIT        0
`define ACSP_RST_CLOCK       8'h01
`define ACSP_RST_PROG        8'h00

// --------------------------------------------------------------
// frame counts
// --------------------------------------------------------------
`define ACSP_INSTR_LAST      4'hf
`define ACSP_BYTE_LAST       4'h7
`define ACSP_LEN_STREAM      2'h3
`define ACSP_STRAP_WAIT      2'h2

`endif

/* rtl/acsp_pkg.sv */
// types shared by the serial configuration port
package acsp_pkg;

  // frame sequencer, gray along idle-instr-data-done
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA  = 2'b11,
    ST_DONE  = 2'b10
  } acsp_state_t;

  // decoded instruction word
  typedef struct packed {
    logic        rw;
    logic [1:0]  len;
    logic [12:0] addr;
  } acsp_instr_t;

  // shared pins after synchronisation
  typedef struct packed {
    logic mrst_b;
    logic sel_b;
    logic sdio;
    logic sclk;
  } acsp_pins_t;

endpackage

/* rtl/acsp_sync.sv */
// two-flop synchroniser with edge detection for the port pins
`timescale 1ns/1ps
module acsp_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // raw pins
  input  wire logic [W-1:0] pin_i,
  // synchronised level and edges
  output logic      [W-1:0] lvl_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] hist_r;

  // ------------------------------------------------------------
  // flops; meta_r feeds sync_r only
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      sync_r <= '0;
      hist_r <= '0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      hist_r <= sync_r;
    end
  end

  assign lvl_o  = sync_r;
  assign rise_o = sync_r & ~hist_r;
  assign fall_o = ~sync_r & hist_r;

endmodule

/* rtl/acsp_port.sv */
// serial configuration port: frame engine, register file and straps
`timescale 1ns/1ps
`include "acsp_map.svh"
module acsp_port #(
  parameter logic [7:0] CHIP_ID_VAL = 8'h5a, // arbitrary identity value
  parameter logic [7:0] GRADE_VAL   = 8'h00  // arbitrary identity value
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // serial pins
  input  wire logic       shift_clock_or_format_strap_i,
  input  wire logic       data_line_or_stabilizer_strap_i,
  input  wire logic       select_low_i,
  input  wire logic       master_reset_b_i,
  output logic            data_line_o,
  output logic            data_line_oe_o,
  // configuration outputs
  output logic            stabilizer_enable_o,
  output logic            twos_complement_o,
  output logic            lsb_first_o,
  output logic            strap_mode_o,
  output logic [7:0]      modes_o
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int k = 0; k < 8; k++) begin
      r[k] = v[7-k];
    end
    return r;
  endfunction

  function automatic logic [7:0] dflt(input int i);
    return (i == `ACSP_CLOCK_IDX) ? `ACSP_RST_CLOCK : `ACSP_RST_PROG;
  endfunction

  function automatic logic in_prog(input logic [7:0] a);
    return (a >= `ACSP_ADDR_PROG_FIRST) && (a <= `ACSP_ADDR_PROG_LAST);
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [3:0]          pin_lvl;
  logic [3:0]          pin_rise;
  logic [3:0]          pin_fall;
  acsp_pkg::acsp_pins_t pins;
  acsp_pkg::acsp_pins_t pins_rise;
  acsp_pkg::acsp_pins_t pins_fall;

  acsp_sync #(
    .W (4)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .pin_i   ({master_reset_b_i, select_low_i,
               data_line_or_stabilizer_strap_i, shift_clock_or_format_strap_i}),
    .lvl_o   (pin_lvl),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  assign pins      = acsp_pkg::acsp_pins_t'(pin_lvl);
  assign pins_rise = acsp_pkg::acsp_pins_t'(pin_rise);
  assign pins_fall = acsp_pkg::acsp_pins_t'(pin_fall);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  acsp_pkg::acsp_state_t state_r;
  acsp_pkg::acsp_state_t state_nxt;
  acsp_pkg::acsp_instr_t instr_r;
  acsp_pkg::acsp_instr_t instr_nxt;
  logic [3:0]            bit_cnt_r;
  logic [3:0]            bit_cnt_nxt;
  logic [15:0]           sr_r;
  logic [15:0]           sr_nxt;
  logic [7:0]            addr_r;
  logic [7:0]            addr_nxt;
  logic [1:0]            byte_cnt_r;
  logic [1:0]            byte_cnt_nxt;
  logic [7:0]            tx_r;
  logic                  sdo_r;
  logic                  oe_r;
  logic                  lsb_first_r;
  logic [7:0]            stage_r [0:`ACSP_PROG_COUNT-1];
  logic [7:0]            act_r   [0:`ACSP_PROG_COUNT-1];
  logic [1:0]            pwr_cnt_r;
  logic                  strap_mode_r;
  logic                  strap_dcs_r;
  logic                  strap_dfs_r;
  logic                  stab_r;
  logic                  twos_r;
  localparam logic [7:0] RST_CLOCK = `ACSP_RST_CLOCK;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire        sclk_rise  = pins_rise.sclk;
  wire        sclk_fall  = pins_fall.sclk;
  wire        sel_fall   = pins_fall.sel_b;
  wire        sel_high   = pins.sel_b;
  wire        mrst_act   = ~pins.mrst_b;
  wire [15:0] shifted    = {sr_r[14:0], pins.sdio};
  wire [15:0] instr_word = lsb_first_r ? {rev8(shifted[7:0]), rev8(shifted[15:8])}
                                       : shifted;
  wire [7:0]  rx_byte    = lsb_first_r ? rev8(shifted[7:0]) : shifted[7:0];
  wire        instr_done = (state_r == acsp_pkg::ST_INSTR) && sclk_rise
                           && (bit_cnt_r == `ACSP_INSTR_LAST);
  wire        byte_done  = (state_r == acsp_pkg::ST_DATA) && sclk_rise
                           && (bit_cnt_r == `ACSP_BYTE_LAST);
  wire        last_byte  = (instr_r.len != `ACSP_LEN_STREAM) && (byte_cnt_r == instr_r.len);
  wire        wr_en      = byte_done && !instr_r.rw;
  wire [7:0]  prog_off   = addr_r - `ACSP_ADDR_PROG_FIRST;
  wire [5:0]  prog_idx   = prog_off[5:0];
  wire        hit_prog   = in_prog(addr_r);
  wire        soft_rst   = wr_en && (addr_r == `ACSP_ADDR_PORT_CFG)
                           && (rx_byte[`ACSP_PC_SRST_HI] || rx_byte[`ACSP_PC_SRST_LO]);
  wire        xfer       = wr_en && (addr_r == `ACSP_ADDR_XFER) && rx_byte[`ACSP_XFER_BIT];
  wire        cfg_dflt   = mrst_act || soft_rst;
  wire [7:0]  port_cfg   = `ACSP_PC_FIXED
                           | ({7'h00, lsb_first_r} << `ACSP_PC_LSB_HI)
                           | ({7'h00, lsb_first_r} << `ACSP_PC_LSB_LO);

  wire [7:0]  rd_val     = (addr_r == `ACSP_ADDR_PORT_CFG) ? port_cfg    :
                           (addr_r == `ACSP_ADDR_CHIP_ID)  ? CHIP_ID_VAL :
                           (addr_r == `ACSP_ADDR_GRADE)    ? GRADE_VAL   :
                           hit_prog                        ? stage_r[prog_idx] :
                                                             8'h00;
  wire [7:0]  tx_src     = (bit_cnt_r == 4'h0) ? rd_val : tx_r;

  // ------------------------------------------------------------
  // frame sequencer next state
  // ------------------------------------------------------------
  always_comb begin
    state_nxt    = state_r;
    instr_nxt    = instr_r;
    bit_cnt_nxt  = bit_cnt_r;
    sr_nxt       = sr_r;
    addr_nxt     = addr_r;
    byte_cnt_nxt = byte_cnt_r;
    case (state_r)
      acsp_pkg::ST_IDLE: begin
        if (sel_fall && !strap_mode_r) begin
          state_nxt   = acsp_pkg::ST_INSTR;
          bit_cnt_nxt = 4'h0;
        end
      end
      acsp_pkg::ST_INSTR: begin
        if (sclk_rise) begin
          sr_nxt      = shifted;
          bit_cnt_nxt = bit_cnt_r + 4'h1;
        end
        if (instr_done) begin
          instr_nxt    = acsp_pkg::acsp_instr_t'(instr_word);
          addr_nxt     = instr_word[7:0];
          byte_cnt_nxt = 2'h0;
          bit_cnt_nxt  = 4'h0;
          state_nxt    = acsp_pkg::ST_DATA;
        end
      end
      acsp_pkg::ST_DATA: begin
        if (sclk_rise) begin
          sr_nxt      = shifted;
          bit_cnt_nxt = bit_cnt_r + 4'h1;
        end
        if (byte_done) begin
          bit_cnt_nxt  = 4'h0;
          byte_cnt_nxt = byte_cnt_r + 2'h1;
          addr_nxt     = lsb_first_r ? addr_r + 8'h01 : addr_r - 8'h01;
          if (last_byte) begin
            state_nxt = acsp_pkg::ST_DONE;
          end
        end
      end
      acsp_pkg::ST_DONE: begin
        state_nxt = acsp_pkg::ST_DONE;
      end
      default: begin
        state_nxt = acsp_pkg::ST_IDLE;
      end
    endcase
    if (sel_high) begin
      state_nxt = acsp_pkg::ST_IDLE;
    end
  end

  // frame state registers on clk_i; shift clock and select edges come through the synchronisers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r    <= acsp_pkg::ST_IDLE;
      instr_r    <= '0;
      bit_cnt_r  <= 4'h0;
      sr_r       <= 16'h0000;
      addr_r     <= 8'h00;
      byte_cnt_r <= 2'h0;
    end else begin
      state_r    <= state_nxt;
      instr_r    <= instr_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      sr_r       <= sr_nxt;
      addr_r     <= addr_nxt;
      byte_cnt_r <= byte_cnt_nxt;
    end
  end

  // ------------------------------------------------------------
  // read data line driver
  // ------------------------------------------------------------
  // launching on the fall gives the controller a half period of setup
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_r  <= 8'h00;
      sdo_r <= 1'b0;
      oe_r  <= 1'b0;
    end else if (sel_high || state_r == acsp_pkg::ST_IDLE) begin
      oe_r <= 1'b0;
    end else if (state_r == acsp_pkg::ST_DONE && sclk_rise) begin
      oe_r <= 1'b0;
    end else if (state_r == acsp_pkg::ST_DATA && instr_r.rw && sclk_fall) begin
      // turn to output for read data
      oe_r  <= 1'b1;
      sdo_r <= lsb_first_r ? tx_src[0] : tx_src[7];
      tx_r  <= lsb_first_r ? {1'b0, tx_src[7:1]} : {tx_src[6:0], 1'b0};
    end
  end

  assign data_line_o    = sdo_r;
  assign data_line_oe_o = oe_r;

  // ------------------------------------------------------------
  // register file: port config, staged and active sets
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lsb_first_r <= 1'b0;
    end else if (cfg_dflt) begin
      lsb_first_r <= 1'b0;
    end else if (wr_en && addr_r == `ACSP_ADDR_PORT_CFG) begin
      // either mirrored bit selects lsb first
      lsb_first_r <= rx_byte[`ACSP_PC_LSB_HI] | rx_byte[`ACSP_PC_LSB_LO];
    end
  end

  // clock control defaults to stabilizer on
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < `ACSP_PROG_COUNT; i++) begin
        stage_r[i] <= dflt(i);
        act_r[i]   <= dflt(i);
      end
    end else if (cfg_dflt) begin
      for (int i = 0; i < `ACSP_PROG_COUNT; i++) begin
        stage_r[i] <= dflt(i);
        act_r[i]   <= dflt(i);
      end
    end else begin
      if (wr_en && hit_prog) begin
        stage_r[prog_idx] <= rx_byte;
      end
      if (xfer) begin
        for (int i = 0; i < `ACSP_PROG_COUNT; i++) begin
          act_r[i] <= stage_r[i];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // power-on straps
  // ------------------------------------------------------------
  // straps are caught once the synchronisers have settled after release
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwr_cnt_r    <= 2'h0;
      strap_mode_r <= 1'b0;
      strap_dcs_r  <= 1'b0;
      strap_dfs_r  <= 1'b0;
    end else begin
      if (pwr_cnt_r != 2'h3) begin
        pwr_cnt_r <= pwr_cnt_r + 2'h1;
      end
      if (pwr_cnt_r == `ACSP_STRAP_WAIT) begin
        // select tied low means strap mode
        strap_mode_r <= ~pins.sel_b;
        strap_dcs_r  <= pins.sdio;
        strap_dfs_r  <= pins.sclk;
      end else if (sel_high) begin
        // port in use once select seen high
        strap_mode_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stab_r <= RST_CLOCK[`ACSP_CLK_DCS_BIT];
      twos_r <= 1'b0;
    end else if (strap_mode_r) begin
      stab_r <= strap_dcs_r;
      twos_r <= strap_dfs_r;
    end else begin
      // bit 0 of clock control is the stabilizer
      stab_r <= act_r[`ACSP_CLOCK_IDX][`ACSP_CLK_DCS_BIT];
      twos_r <= 1'b0;
    end
  end

  assign stabilizer_enable_o = stab_r;
  assign twos_complement_o   = twos_r;
  assign lsb_first_o         = lsb_first_r;
  assign strap_mode_o        = strap_mode_r;
  assign modes_o             = act_r[0];

endmodule

/* tb/acsp_port_monitor.sv */
// assertion checker for the serial configuration port
`timescale 1ns/1ps
module acsp_port_monitor (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  // serial pins
  input wire logic       shift_clock_or_format_strap_i,
  input wire logic       data_line_or_stabilizer_strap_i,
  input wire logic       select_low_i,
  input wire logic       master_reset_b_i,
  input wire logic       data_line_o,
  input wire logic       data_line_oe_o,
  // configuration outputs
  input wire logic       stabilizer_enable_o,
  input wire logic       twos_complement_o,
  input wire logic       lsb_first_o,
  input wire logic       strap_mode_o,
  input wire logic [7:0] modes_o
);
  // ----
  // pin aliases; pins reach the logic through two flops, hence the depths
  // ----
  wire logic sck = shift_clock_or_format_strap_i;
  wire logic sel = select_low_i;
  wire logic mrn = master_reset_b_i;
  wire logic oe  = data_line_oe_o;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_oe_on_fall: assert property (
    $rose(oe) |-> !$past(sck, 2) && !$past(sel, 2)) else $error("oe rose off a fall");
  a_oe_off_rise: assert property (
    $fell(oe) |-> $past(sck, 2) || $past(sel, 2)) else $error("oe fell off a rise");
  a_sel_idle: assert property (
    sel [*6] |-> !oe) else $error("line driven while deselected");
  a_data_on_fall: assert property (
    oe && $changed(data_line_o) |-> !$past(sck, 2)) else $error("read bit moved off a fall");
  a_modes_quiet: assert property (
    $changed(modes_o) |-> !$past(sel, 3) || !$past(mrn, 3) || !$past(mrn, 4))
    else $error("modes moved outside a frame");
  a_stab_quiet: assert property (
    $changed(stabilizer_enable_o) && !strap_mode_o && !$past(strap_mode_o)
    && !$past(strap_mode_o, 2) |-> !$past(sel, 3) || !$past(mrn, 3) || !$past(mrn, 4))
    else $error("stabilizer moved outside a frame");
  a_lsb_quiet: assert property (
    $changed(lsb_first_o) |-> !$past(sel, 3) || !$past(mrn, 3) || !$past(mrn, 4))
    else $error("bit order moved outside a frame");
  a_mrst_defaults: assert property (
    !mrn [*5] |-> modes_o == 8'h00 && !lsb_first_o) else $error("defaults not held");
  a_strap_level: assert property (
    strap_mode_o && $past(strap_mode_o) |-> twos_complement_o == $past(sck, 4)
    && stabilizer_enable_o == $past(data_line_or_stabilizer_strap_i, 4))
    else $error("strap level not followed");
  a_twos_off: assert property (
    !strap_mode_o && !$past(strap_mode_o) |-> !twos_complement_o)
    else $error("twos set outside strap mode");
  a_strap_entry: assert property (
    $rose(strap_mode_o) |-> !$past(sel, 2)) else $error("strap mode without select low");

  c_read: cover property ($rose(oe));
  c_strap: cover property ($rose(strap_mode_o));
  c_stab_off: cover property ($fell(stabilizer_enable_o) && !strap_mode_o);
endmodule

bind acsp_port acsp_port_monitor u_mon (
  .clk_i, .rst_b_i, .shift_clock_or_format_strap_i, .data_line_or_stabilizer_strap_i,
  .select_low_i, .master_reset_b_i, .data_line_o, .data_line_oe_o, .stabilizer_enable_o,
  .twos_complement_o, .lsb_first_o, .strap_mode_o, .modes_o);

/* tb/acsp_ctrl_model.sv */
// programming controller model for the three-wire link
`timescale 1ns/1ps
module acsp_ctrl_model (
  // bench clock; frames start just after its edge so link edges never race it
  input  wire logic clk_i,
  // link pins
  output logic      sclk_o,
  output logic      sel_b_o,
  output logic      sd_o,
  output logic      sd_oe_o,
  input  wire logic sd_i
);
  // ----
  // link idles with the clock still and the line released
  // ----
  initial begin
    sclk_o = 1'b0;
    sel_b_o = 1'b1;
    sd_o = 1'b0;
    sd_oe_o = 1'b0;
  end

  task automatic pins(input logic s, input logic c, input logic d, input logic o);
    sel_b_o = s;
    sclk_o = c;
    sd_o = d;
    sd_oe_o = o;
  endtask

  // select fall, then nb bits: sixteen instruction bits, then data bits
  task automatic frame(input logic [15:0] ins, input logic [15:0] wd, input int nb,
                       input logic lsb, output logic [15:0] rd);
    int i;
    int p;
    rd = 16'h0000;
    @(posedge clk_i);
    #1 sel_b_o = 1'b0;
    #80;
    for (i = 0; i < nb; i++) begin
      if (i < 16) p = lsb ? i : 15 - i;
      else p = (31 - i) / 8 * 8 + (lsb ? (i - 16) % 8 : 7 - (i - 16) % 8);
      // data set while the clock is low; read phase leaves the line
      sd_oe_o = (i < 16) || !ins[15];
      sd_o = (i < 16) ? ins[p] : wd[p];
      #80 sclk_o = 1'b1;
      #80;
      if (i >= 16) rd[p] = sd_i;
      sclk_o = 1'b0;
    end
    sd_oe_o = 1'b0;
    #80 sel_b_o = 1'b1;
    #160;
  endtask
endmodule

/* tb/adc_serial_config_port_bench.sv */
// self-checking bench for the serial configuration port
`timescale 1ns/1ps
module adc_serial_config_port_bench;
  logic        clk;
  logic        rst_b;
  logic        mrst_b;
  logic        lsb_m;
  int          err_count;
  int          checked;
  logic        sck;
  logic        sel_b;
  logic        c_d;
  logic        c_oe;
  logic        d_d;
  logic        d_oe;
  logic        stab;
  logic        twos;
  logic        lsb;
  logic        strap;
  logic [7:0]  modes;
  logic [15:0] r;
  // pull-up holds the released line high
  wire  logic       sd_w = d_oe ? d_d : (c_oe ? c_d : 1'b1);
  wire  logic [7:0] flg  = {3'h0, d_oe, stab, twos, lsb, strap};

  acsp_port DUT (
    .clk_i(clk),
    .rst_b_i(rst_b),
    .shift_clock_or_format_strap_i(sck),
    .data_line_or_stabilizer_strap_i(sd_w),
    .select_low_i(sel_b),
    .master_reset_b_i(mrst_b),
    .data_line_o(d_d),
    .data_line_oe_o(d_oe),
    .stabilizer_enable_o(stab),
    .twos_complement_o(twos),
    .lsb_first_o(lsb),
    .strap_mode_o(strap),
    .modes_o(modes)
  );
  acsp_ctrl_model ctrl (.clk_i(clk), .sclk_o(sck), .sel_b_o(sel_b), .sd_o(c_d), .sd_oe_o(c_oe),
                        .sd_i(sd_w));

  // ----
  // tasks
  // ----
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ctrl.frame({8'h00, a}, {d, 8'h00}, 24, lsb_m, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    ctrl.frame({8'h80, a}, 16'h0000, 24, lsb_m, r);
    cmp8(r[15:8], e);
  endtask

  task automatic end_sim;
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // frames take a few microseconds each; a hang runs far past this
  initial begin
    #1000000;
    err_count++;
    end_sim();
  end

  initial begin
    rst_b = 1'b0;
    mrst_b = 1'b1;
    lsb_m = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (8) @(posedge clk);
    cmp8(flg, 8'h08);
    cmp8(modes, 8'h00);
    rd(8'h09, 8'h01);
    rd(8'h08, 8'h00);
    wr(8'h09, 8'h00);
    cmp8(flg, 8'h08);
    rd(8'h09, 8'h00);
    wr(8'hff, 8'h01);
    cmp8(flg, 8'h00);
    ctrl.frame(16'h2009, 16'h01a5, 32, 1'b0, r);
    wr(8'hff, 8'h01);
    cmp8(modes, 8'ha5);
    cmp8(flg, 8'h08);
    ctrl.frame(16'ha009, 16'h0000, 32, 1'b0, r);
    cmp8(r[15:8], 8'h01);
    cmp8(r[7:0], 8'ha5);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h5a);
    rd(8'h30, 8'h00);
    ctrl.frame(16'h0008, 16'h3c00, 20, 1'b0, r);
    rd(8'h08, 8'ha5);
    wr(8'h00, 8'h42);
    cmp8(flg, 8'h0a);
    lsb_m = 1'b1;
    rd(8'h09, 8'h01);
    wr(8'h00, 8'h24);
    lsb_m = 1'b0;
    cmp8(flg, 8'h08);
    wr(8'h08, 8'h33);
    wr(8'hff, 8'h01);
    cmp8(modes, 8'h33);
    ctrl.frame(16'h6009, 16'h0144, 32, 1'b0, r);
    ctrl.frame(16'h8009, 16'h0000, 25, 1'b0, r);
    cmp8(r[15:8], 8'h01);
    rd(8'h08, 8'h44);
    @(posedge clk);
    #1 mrst_b = 1'b0;
    repeat (10) @(posedge clk);
    #1 mrst_b = 1'b1;
    cmp8(modes, 8'h00);
    rd(8'h08, 8'h00);
    @(posedge clk);
    #1 rst_b = 1'b0;
    ctrl.pins(1'b0, 1'b1, 1'b0, 1'b1);
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (8) @(posedge clk);
    cmp8(flg, 8'h05);
    ctrl.pins(1'b1, 1'b1, 1'b0, 1'b1);
    repeat (8) @(posedge clk);
    cmp8(flg, 8'h08);
    end_sim();
  end
endmodule
